// ==== rtl/fault_irq_defs.vh ====
/*
 * constants for the fault flag and charger mask register block.
 * assumes inclusion by bare name from the design file.
 */
`ifndef FAULT_IRQ_DEFS_VH
`define FAULT_IRQ_DEFS_VH

// ****************************************************************
// register addresses and resets
// ****************************************************************
`define FAULT_FLAG_ADDR 8'h25
`define IRQ_MASK_ADDR 8'h26
`define FAULT_FLAG_RESET 8'h00
`define IRQ_MASK_RESET 8'h00
`define RESERVED_FLAG_BITS 8'h06

// ****************************************************************
// fault flag bit positions
// ****************************************************************
`define FLG_INPUT_OV 7
`define FLG_BATTERY_OV 6
`define FLG_SYSTEM_RAIL 5
`define FLG_BOOST_OUT 4
`define FLG_DIE_OVERHEAT 3
`define FLG_TEMP_ZONE 0

// ****************************************************************
// mask bit positions
// ****************************************************************
`define MSK_POWER_GOOD 7
`define MSK_CONV_DONE 6
`define MSK_THERMAL_REG 5
`define MSK_MIN_SYSTEM 4
`define MSK_INPUT_CURRENT 3
`define MSK_INPUT_VOLTAGE 2
`define MSK_CHARGE_TIMER 1
`define MSK_WATCHDOG 0

// ****************************************************************
// interrupt pulse
// ****************************************************************
`define IRQ_PULSE_NS 256
`define CLK_PERIOD_NS 10

`endif

// ==== rtl/charger_fault_flag_int_mask.v ====
/*
 * fault flag register (clear on read) and charger interrupt mask
 * register with a fixed-width interrupt pulse generator.
 * assumes the serial host interface hands over decoded single-cycle
 * read and write strobes with an address, and that event inputs are
 * asynchronous levels from the analog side.
 */
`timescale 1ns/100ps
`include "fault_irq_defs.vh"
`default_nettype none

module charger_fault_flag_int_mask #(
  parameter PULSE_NS = `IRQ_PULSE_NS
) (
  input wire CLK,
  input wire RST_B,
  input wire REG_RESET_CMD,
  input wire RD_STB,
  input wire WR_STB,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire [7:0] FAULT_LEVELS,
  input wire [7:0] CHARGER_LEVELS,
  output reg [7:0] RDATA,
  output reg INT_PULSE
);

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam PULSE_CYC_I = (PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam PULSE_CYC = (PULSE_CYC_I < 1) ? 1 : PULSE_CYC_I;
  localparam [15:0] PULSE_LAST = PULSE_CYC - 1;

  // ****************************************************************
  // input synchronisers and edge detect
  // ****************************************************************
  reg [7:0] fault_meta_reg;
  reg [7:0] fault_sync_reg;
  reg [7:0] fault_prev_reg;
  reg [7:0] chg_meta_reg;
  reg [7:0] chg_sync_reg;
  reg [7:0] chg_prev_reg;
  reg [7:0] fault_flag_reg;
  reg [7:0] fault_flag_next;
  reg [7:0] mask_reg;
  reg [7:0] mask_next;
  reg [15:0] pulse_cnt_reg;
  reg [7:0] fault_rise;
  reg [7:0] chg_event;
  reg irq_req;
  wire [7:0] chg_rise;
  wire [7:0] chg_fall;

  assign chg_rise = chg_sync_reg & ~chg_prev_reg;
  assign chg_fall = ~chg_sync_reg & chg_prev_reg;

  always @(posedge CLK) begin
    if (!RST_B) begin
      fault_meta_reg <= 8'h00;
      fault_sync_reg <= 8'h00;
      fault_prev_reg <= 8'h00;
      chg_meta_reg <= 8'h00;
      chg_sync_reg <= 8'h00;
      chg_prev_reg <= 8'h00;
    end else begin
      fault_meta_reg <= FAULT_LEVELS;
      fault_sync_reg <= fault_meta_reg;
      fault_prev_reg <= fault_sync_reg;
      chg_meta_reg <= CHARGER_LEVELS;
      chg_sync_reg <= chg_meta_reg;
      chg_prev_reg <= chg_sync_reg;
    end
  end

  // ****************************************************************
  // event decode
  // ****************************************************************
  always @* begin
    fault_rise = fault_sync_reg & ~fault_prev_reg;
    fault_rise[`FLG_INPUT_OV] = fault_sync_reg[`FLG_INPUT_OV] &
      ~fault_prev_reg[`FLG_INPUT_OV];
    fault_rise[`FLG_BATTERY_OV] = fault_sync_reg[`FLG_BATTERY_OV] &
      ~fault_prev_reg[`FLG_BATTERY_OV];
    fault_rise[`FLG_SYSTEM_RAIL] = fault_sync_reg[`FLG_SYSTEM_RAIL] &
      ~fault_prev_reg[`FLG_SYSTEM_RAIL];
    fault_rise[`FLG_BOOST_OUT] = fault_sync_reg[`FLG_BOOST_OUT] &
      ~fault_prev_reg[`FLG_BOOST_OUT];
    fault_rise[`FLG_DIE_OVERHEAT] = fault_sync_reg[`FLG_DIE_OVERHEAT] &
      ~fault_prev_reg[`FLG_DIE_OVERHEAT];
    fault_rise[`FLG_TEMP_ZONE] = fault_sync_reg[`FLG_TEMP_ZONE] ^
      fault_prev_reg[`FLG_TEMP_ZONE];
    fault_rise = fault_rise & ~`RESERVED_FLAG_BITS;
    chg_event = chg_rise;
    chg_event[`MSK_POWER_GOOD] = chg_rise[`MSK_POWER_GOOD] |
      chg_fall[`MSK_POWER_GOOD];
    chg_event[`MSK_MIN_SYSTEM] = chg_rise[`MSK_MIN_SYSTEM] |
      chg_fall[`MSK_MIN_SYSTEM];
  end

  // ****************************************************************
  // interrupt request
  // ****************************************************************
  always @* begin
    irq_req = 1'b0;
    irq_req = irq_req | (chg_event[`MSK_POWER_GOOD] &
      ~mask_reg[`MSK_POWER_GOOD]);
    irq_req = irq_req | (chg_event[`MSK_CONV_DONE] &
      ~mask_reg[`MSK_CONV_DONE]);
    irq_req = irq_req | (chg_event[`MSK_THERMAL_REG] &
      ~mask_reg[`MSK_THERMAL_REG]);
    irq_req = irq_req | (chg_event[`MSK_MIN_SYSTEM] &
      ~mask_reg[`MSK_MIN_SYSTEM]);
    irq_req = irq_req | (chg_event[`MSK_INPUT_CURRENT] &
      ~mask_reg[`MSK_INPUT_CURRENT]);
    irq_req = irq_req | (chg_event[`MSK_INPUT_VOLTAGE] &
      ~mask_reg[`MSK_INPUT_VOLTAGE]);
    irq_req = irq_req | (chg_event[`MSK_CHARGE_TIMER] &
      ~mask_reg[`MSK_CHARGE_TIMER]);
    irq_req = irq_req | (chg_event[`MSK_WATCHDOG] &
      ~mask_reg[`MSK_WATCHDOG]);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always @* begin
    fault_flag_next = fault_flag_reg;
    if (RD_STB && ADDR == `FAULT_FLAG_ADDR) begin
      fault_flag_next = `FAULT_FLAG_RESET;
    end
    // set wins over clear on read; mask plays no part
    fault_flag_next = fault_flag_next | fault_rise;
    mask_next = mask_reg;
    if (WR_STB && ADDR == `IRQ_MASK_ADDR) begin
      mask_next = WDATA;
    end
    if (REG_RESET_CMD) begin
      mask_next = `IRQ_MASK_RESET;
    end
  end

  always @(posedge CLK) begin
    if (!RST_B) begin
      fault_flag_reg <= `FAULT_FLAG_RESET;
      mask_reg <= `IRQ_MASK_RESET;
      RDATA <= 8'h00;
      INT_PULSE <= 1'b0;
      pulse_cnt_reg <= 16'h0000;
    end else begin
      fault_flag_reg <= fault_flag_next;
      mask_reg <= mask_next;
      if (RD_STB) begin
        case (ADDR)
          `FAULT_FLAG_ADDR: RDATA <= fault_flag_reg;
          `IRQ_MASK_ADDR: RDATA <= mask_reg;
          default: RDATA <= 8'h00;
        endcase
      end
      if (irq_req) begin
        INT_PULSE <= 1'b1;
        pulse_cnt_reg <= PULSE_LAST;
      end else if (pulse_cnt_reg != 16'h0000) begin
        pulse_cnt_reg <= pulse_cnt_reg - 16'h0001;
      end else begin
        INT_PULSE <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ==== bench/fault_irq_checker.sv ====
/* checker for the flag and mask block. assumes a bind to its top. */
`timescale 1ns/100ps
`default_nettype none
module fault_irq_checker #(
  parameter PULSE_NS = 256
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic REG_RESET_CMD,
  input wire logic RD_STB,
  input wire logic WR_STB,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic [7:0] FAULT_LEVELS,
  input wire logic [7:0] CHARGER_LEVELS,
  input wire logic [7:0] RDATA,
  input wire logic INT_PULSE
);
  localparam int PC = (PULSE_NS + 9) / 10;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  property p_hold; !RD_STB |=> $stable(RDATA); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_rsv; RD_STB && ADDR == 8'h25 |=> RDATA[2:1] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  property p_unmap;
    RD_STB && ADDR != 8'h25 && ADDR != 8'h26 |=> RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped");
  property p_clr; ($stable(FAULT_LEVELS))[*6] ##0 RD_STB && ADDR == 8'h25
    && $past(RD_STB && ADDR == 8'h25, 2) |=> RDATA == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("no clear");
  property p_wr; WR_STB && ADDR == 8'h26 && !REG_RESET_CMD ##1
    !WR_STB && !REG_RESET_CMD ##1 RD_STB && ADDR == 8'h26 &&
    !REG_RESET_CMD |=> RDATA == $past(WDATA, 3); endproperty
  a_wr: assert property (p_wr) else $error("mask readback");
  property p_rcmd; REG_RESET_CMD ##1 (!WR_STB)[*2] ##0 RD_STB &&
    ADDR == 8'h26 |=> RDATA == 8'h00; endproperty
  a_rcmd: assert property (p_rcmd) else $error("mask kept");
  property p_plen; $fell(INT_PULSE) |-> $past(INT_PULSE, PC); endproperty
  a_plen: assert property (p_plen) else $error("short pulse");
  property p_rise; $rose(INT_PULSE) |->
    $past(CHARGER_LEVELS, 2) != $past(CHARGER_LEVELS, 6); endproperty
  a_rise: assert property (p_rise) else $error("stray pulse");
endmodule
bind charger_fault_flag_int_mask fault_irq_checker #(
  .PULSE_NS(PULSE_NS)) chk (.*);
`default_nettype wire

// ==== bench/host_irq_model.sv ====
/* host side: counts interrupt pulses. assumes an active-high pulse. */
`timescale 1ns/100ps
`default_nettype none
module host_irq_model (
  input wire logic clk,
  input wire logic irq,
  output logic [7:0] pulses = 8'h00
);
  logic irq_d = 1'b0;
  // each pulse is one service call; flag reads done by bench
  always @(posedge clk) begin
    irq_d <= irq;
    if (irq && !irq_d) pulses <= pulses + 8'h01;
  end
endmodule
`default_nettype wire

// ==== bench/charger_fault_flag_int_mask_bench.sv ====
/* bench for the flag and mask block. assumes checker and host model. */
`timescale 1ns/100ps
`default_nettype none
module charger_fault_flag_int_mask_bench;
  logic CLK = 1'b0, RST_B = 1'b0, REG_RESET_CMD = 1'b0;
  logic RD_STB = 1'b0, WR_STB = 1'b0, INT_PULSE;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, p, q, e;
  logic [7:0] FAULT_LEVELS = 8'h00, CHARGER_LEVELS = 8'h00;
  int error_cnt = 0, num_checks = 0, cyc = 0, i;
  charger_fault_flag_int_mask dut (.*);
  host_irq_model host (.clk(CLK), .irq(INT_PULSE), .pulses(p));
  initial forever #5 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      finish_test;
    end
  end
  task chk(input string s, input logic [7:0] g, x);
    num_checks++;
    if (g !== x) begin
      $display("[ERR] %s exp %h got %h", s, x, g);
      error_cnt++;
    end
  endtask
  task wt(input int c);
    repeat (c) @(negedge CLK);
  endtask
  task wr(input logic [7:0] a, d);
    @(negedge CLK) {WR_STB, ADDR, WDATA} = {1'b1, a, d};
    @(negedge CLK) WR_STB = 1'b0;
  endtask
  task rd(input logic [7:0] a, x);
    @(negedge CLK) {RD_STB, ADDR} = {1'b1, a};
    @(negedge CLK) RD_STB = 1'b0;
    chk("rdata", RDATA, x);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    wt(20);
    RST_B = 1'b1;
    rd(8'h25, 8'h00);
    rd(8'h26, 8'h00);
    rd(8'h40, 8'h00);
    wr(8'h25, 8'hff);
    wr(8'h26, 8'ha5);
    rd(8'h26, 8'ha5);
    rd(8'h25, 8'h00);
    $display("registers done");
    for (i = 0; i < 8; i++) begin
      FAULT_LEVELS = 8'h01 << i;
      e = FAULT_LEVELS & 8'hf9 | {7'h00, i == 1};
      wt(6);
      rd(8'h25, e);
      rd(8'h25, 8'h00);
    end
    chk("pulses", p, 8'h00);
    $display("flags done");
    q = 8'h00;
    for (i = 0; i < 8; i++) begin
      wr(8'h26, 8'h00);
      CHARGER_LEVELS[i] = 1'b1;
      wt(32);
      q++;
      chk("pulses", p, q);
      wr(8'h26, 8'h01 << i);
      CHARGER_LEVELS[i] = 1'b0;
      wt(32);
      CHARGER_LEVELS[i] = 1'b1;
      wt(32);
      chk("pulses", p, q);
      wr(8'h26, 8'h00);
      CHARGER_LEVELS[i] = 1'b0;
      wt(32);
      if (i == 7 || i == 4) q++;
      chk("pulses", p, q);
    end
    $display("masks done");
    wr(8'h26, 8'hff);
    REG_RESET_CMD = 1'b1;
    wr(8'h26, 8'h5a);
    REG_RESET_CMD = 1'b0;
    rd(8'h26, 8'h00);
    $display("register reset done");
    finish_test;
  end
endmodule
`default_nettype wire
